/* File: hw/rfseq_page_map.sv */
// tag byte address to page number and range check
`timescale 1ns/100ps
`default_nettype none
module rfseq_page_map (
    // address in
    input  wire logic [7:0] addr,
    input  wire logic       large_tag,
    // page out
    output logic [4:0]      page,
    output logic            addr_ok
);
    always_comb begin
        page = 5'(addr >> rfseq_pkg::PAGE_SHIFT) + rfseq_pkg::PAGE_FIRST;
        if (large_tag) begin
            addr_ok = (addr <= rfseq_pkg::ADDR_LAST);
        end else begin
            addr_ok = (addr <= rfseq_pkg::SMALL_USER_LAST);
        end
    end
endmodule : rfseq_page_map
`default_nettype wire

/* File: hw/rfseq_top.sv */
// operation sequencer of the rfid reader/writer module
`timescale 1ns/100ps
`default_nettype none
module rfseq_top #(
    parameter int unsigned INIT_CYCLES = rfseq_pkg::INIT_CYCLES
) (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // abort input, active low
    input  wire logic                     abort_n,
    // serial front end: command frames
    input  wire logic                     cmd_start,
    input  wire logic                     cmd_valid,
    input  wire rfseq_pkg::rfseq_cmd_type cmd,
    // tag engine
    output logic                          tag_go,
    output logic [4:0]                    tag_page,
    input  wire logic                     tag_done,
    input  wire logic                     tag_ok,
    // response path
    output logic                          resp_go,
    output logic                          resp_ok,
    input  wire logic                     resp_done,
    // antenna and status
    output logic                          antenna_on,
    output logic                          osc_continuous,
    output rfseq_pkg::rfseq_status_type   status,
    output logic                          addr_error
);
    rfseq_pkg::rfseq_state_type state_q, state_d;
    logic [rfseq_pkg::INIT_CNT_W-1:0] cnt_q, cnt_d;
    logic             cont_q, cont_d;
    logic             succ_q, succ_d;
    logic             fail_q, fail_d;
    logic             aerr_q, aerr_d;
    logic             rok_q, rok_d;
    logic [4:0]       page_q, page_d;
    rfseq_pkg::rfseq_cmd_type cmd_q, cmd_d;
    logic [4:0]       map_page;
    logic             map_ok;


    // byte address to page number and tag size range check
    rfseq_page_map rfseq_page_map_i (
        .addr      (cmd_q.addr),
        .large_tag (cmd_q.large_tag),
        .page      (map_page),
        .addr_ok   (map_ok)
    );

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        cont_d  = cont_q;
        succ_d  = succ_q;
        fail_d  = fail_q;
        aerr_d  = aerr_q;
        rok_d   = rok_q;
        page_d  = page_q;
        cmd_d   = cmd_q;
        unique case (state_q)
            rfseq_pkg::RFSEQ_INIT: begin
                if (cnt_q >= rfseq_pkg::INIT_CNT_W'(INIT_CYCLES - 1)) begin
                    state_d = rfseq_pkg::RFSEQ_IDLE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            rfseq_pkg::RFSEQ_IDLE: begin
                if (cmd_start) begin
                    state_d = rfseq_pkg::RFSEQ_RECV;
                end
            end
            rfseq_pkg::RFSEQ_RECV: begin
                if (cmd_valid) begin
                    cmd_d   = cmd;
                    succ_d  = 1'b0;
                    fail_d  = 1'b0;
                    state_d = rfseq_pkg::RFSEQ_PROC;
                    if (cmd.osc_off) begin
                        cont_d = 1'b0;
                    end else if (cmd.osc_on || cmd.fifo_opt) begin
                        cont_d = 1'b1;
                    end
                end
            end
            rfseq_pkg::RFSEQ_PROC: begin
                page_d = map_page;
                aerr_d = !map_ok;
                if (!map_ok) begin
                    fail_d  = 1'b1;
                    rok_d   = 1'b0;
                    state_d = rfseq_pkg::RFSEQ_RESP;
                end else if (tag_done) begin
                    succ_d  = tag_ok;
                    fail_d  = !tag_ok;
                    rok_d   = tag_ok;
                    state_d = rfseq_pkg::RFSEQ_RESP;
                end
            end
            rfseq_pkg::RFSEQ_RESP: begin
                if (resp_done) begin
                    state_d = rfseq_pkg::RFSEQ_IDLE;
                end
            end
            rfseq_pkg::RFSEQ_HALT: begin
                state_d = rfseq_pkg::RFSEQ_IDLE;
            end
        endcase
        // abort overrides in every state but RFSEQ_INIT; a partial multipage write is left as is
        if (!abort_n && state_q != rfseq_pkg::RFSEQ_INIT) begin
            state_d = rfseq_pkg::RFSEQ_HALT;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= rfseq_pkg::RFSEQ_INIT;
            cnt_q   <= '0;
            cont_q  <= 1'b0;
            succ_q  <= 1'b0;
            fail_q  <= 1'b0;
            aerr_q  <= 1'b0;
            rok_q   <= 1'b0;
            page_q  <= '0;
            cmd_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            cont_q  <= cont_d;
            succ_q  <= succ_d;
            fail_q  <= fail_d;
            aerr_q  <= aerr_d;
            rok_q   <= rok_d;
            page_q  <= page_d;
            cmd_q   <= cmd_d;
        end
    end

    // handshakes and status
    // tag_go, resp_go, antenna_on and module_alive drop in the same cycle as the abort input falls
    always_comb begin
        tag_go   = (state_q == rfseq_pkg::RFSEQ_PROC) && map_ok && abort_n;
        tag_page = page_q;
        resp_go  = (state_q == rfseq_pkg::RFSEQ_RESP) && abort_n;
        resp_ok  = rok_q;
        osc_continuous = cont_q;
        // stop mode only oscillates in RFSEQ_PROC, while the tag engine runs
        antenna_on = abort_n && (state_q != rfseq_pkg::RFSEQ_INIT)
                   && (cont_q || state_q == rfseq_pkg::RFSEQ_PROC);
        status.tag_link_active = tag_go;
        status.tag_success     = succ_q;
        status.tag_failure     = fail_q;
        status.module_alive    = abort_n
                               && (state_q != rfseq_pkg::RFSEQ_INIT);
        addr_error = aerr_q;
    end
endmodule : rfseq_top
`default_nettype wire

/* File: shared/rfseq_pkg.sv */
// package for the rfid reader/writer operation sequencer
package rfseq_pkg;
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned INIT_TIME_MS   = 50;
    localparam int unsigned INIT_CYCLES    = (CLK_HZ / 1000) * INIT_TIME_MS;
    localparam int unsigned INIT_CNT_W     = 22;
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned PAGE_W         = 5;
    localparam int unsigned PAGE_SHIFT     = 3;
    localparam logic [7:0]  ADDR_LAST      = 8'hEF;
    localparam logic [7:0]  SMALL_TAG_SIZE = 8'h80;
    localparam logic [7:0]  SMALL_USER_LAST = 8'h6F;
    localparam logic [4:0]  PAGE_FIRST     = 5'h01;

    typedef enum logic [5:0] {
        RFSEQ_INIT = 6'b000001,
        RFSEQ_IDLE = 6'b000010,
        RFSEQ_RECV = 6'b000100,
        RFSEQ_PROC = 6'b001000,
        RFSEQ_RESP = 6'b010000,
        RFSEQ_HALT = 6'b100000
    } rfseq_state_type;

    // command as decoded by the serial front end
    typedef struct packed {
        logic       osc_off;
        logic       osc_on;
        logic       fifo_opt;
        logic       large_tag;
        logic [7:0] addr;
    } rfseq_cmd_type;

    // status lamps
    typedef struct packed {
        logic tag_link_active;
        logic tag_success;
        logic tag_failure;
        logic module_alive;
    } rfseq_status_type;
endpackage : rfseq_pkg

/* File: tb/rfseq_sva.sv */
// assertions on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
module rfseq_sva (
    // clock, reset, abort
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input wire logic                        abort_n,
    // handshakes and status
    input wire logic                        tag_go,
    input wire logic                        tag_done,
    input wire logic                        tag_ok,
    input wire logic                        resp_go,
    input wire logic                        resp_done,
    input wire logic                        antenna_on,
    input wire logic                        osc_continuous,
    input wire rfseq_pkg::rfseq_status_type status
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_tag_end; tag_go && tag_done; endsequence
    property p_abort;
        !abort_n |-> !(antenna_on | tag_go | resp_go | status.module_alive);
    endproperty
    a_abort: assert property (p_abort) else $error("abort");
    property p_link; tag_go |-> antenna_on && status.tag_link_active; endproperty
    a_link: assert property (p_link) else $error("link");
    property p_cont; osc_continuous && status.module_alive |-> antenna_on; endproperty
    a_cont: assert property (p_cont) else $error("cont");
    property p_low; resp_go && !osc_continuous |-> !antenna_on; endproperty
    a_low: assert property (p_low) else $error("low");
    property p_ok; s_tag_end ##0 tag_ok |=> status.tag_success; endproperty
    a_ok: assert property (p_ok) else $error("ok");
    property p_bad; s_tag_end ##0 !tag_ok |=> status.tag_failure; endproperty
    a_bad: assert property (p_bad) else $error("bad");
    property p_resp; s_tag_end ##1 abort_n |-> resp_go; endproperty
    a_resp: assert property (p_resp) else $error("resp");
    property p_hold; resp_go && !resp_done |=> resp_go || !abort_n; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_alive; $past(status.module_alive) && abort_n |-> status.module_alive;
    endproperty
    a_alive: assert property (p_alive) else $error("alive");
endmodule : rfseq_sva
`default_nettype wire

/* File: tb/rfseq_tag_model.sv */
// tag engine and response path partner
`timescale 1ns/100ps
`default_nettype none
module rfseq_tag_model (
    // from sequencer; mclk, wait_cyc and ok from the bench
    input wire logic       mclk,
    input wire logic       tag_go,
    input wire logic       resp_go,
    input wire logic [3:0] wait_cyc,
    input wire logic       ok,
    // answers
    output logic           tag_done,
    output logic           tag_ok,
    output logic           resp_done
);
    logic [3:0] cnt_q = 4'h0;
    always_ff @(posedge mclk) begin
        cnt_q <= (tag_go | resp_go) & !(tag_done | resp_done) ? cnt_q + 4'h1 : 4'h0;
    end
    assign tag_done = tag_go && cnt_q == wait_cyc;
    assign resp_done = resp_go && cnt_q == wait_cyc;
    assign tag_ok = tag_done ? ok : !ok;
endmodule : rfseq_tag_model
`default_nettype wire

/* File: tb/rfseq_top_tb.sv */
// self-checking bench for the operation sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module rfseq_top_tb;
    logic                        mclk = 1'b0, rst_n = 1'b0, abort_n = 1'b1;
    logic                        cmd_start = 1'b0, cmd_valid = 1'b0, ok = 1'b1;
    logic                        tag_go, tag_done, tag_ok, resp_go, resp_ok;
    logic                        resp_done, antenna_on, osc_continuous;
    logic                        addr_error, go_seen, cont = 1'b0;
    logic [4:0]                  tag_page, pg_seen = 5'h00;
    logic [3:0]                  wait_cyc = 4'h1;
    logic [11:0]                 tbl [7] = '{12'h000, 12'h1EF, 12'h070,
                                             12'h408, 12'hA10, 12'h26F, 12'h800};
    rfseq_pkg::rfseq_cmd_type    cmd = '0;
    rfseq_pkg::rfseq_status_type status;
    int                          n_mismatch = 0, samples_checked = 0, k;
    rfseq_top #(.INIT_CYCLES(16)) rfseq_top_i (.mclk, .rst_n, .abort_n,
        .cmd_start, .cmd_valid, .cmd, .tag_go, .tag_page, .tag_done, .tag_ok,
        .resp_go, .resp_ok, .resp_done, .antenna_on, .osc_continuous, .status,
        .addr_error);
    rfseq_tag_model rfseq_tag_model_i (.mclk, .tag_go, .resp_go, .wait_cyc,
        .ok, .tag_done, .tag_ok, .resp_done);
    initial forever #12.5 mclk = ~mclk;
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic wait_resp(input logic lvl);
        for (k = 0; resp_go !== lvl; k++) begin
            if (k == 60) begin
                n_mismatch++;
                give_verdict();
            end
            @(negedge mclk);
            go_seen |= tag_go;
            if (tag_done) pg_seen = tag_page;
        end
    endtask : wait_resp
    task automatic issue(input rfseq_pkg::rfseq_cmd_type c);
        go_seen = 1'b0;
        cmd_start = 1'b1;
        @(negedge mclk);
        cmd_start = 1'b0;
        cmd_valid = 1'b1;
        cmd = c;
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask : issue
    task automatic run(input rfseq_pkg::rfseq_cmd_type c, input logic good);
        logic bad;
        bad = c.addr > (c.large_tag ? 8'hEF : 8'h6F);
        if (c.osc_off) cont = 1'b0;
        else if (c.osc_on || c.fifo_opt) cont = 1'b1;
        ok = good;
        issue(c);
        wait_resp(1'b1);
        `CHK("tag_go", !bad, go_seen)
        if (!bad) `CHK("page", 5'(c.addr >> 3) + 5'h01, pg_seen)
        `CHK("success", good && !bad, status.tag_success)
        `CHK("failure", !good || bad, status.tag_failure)
        `CHK("addr_error", bad, addr_error)
        `CHK("resp_ok", good && !bad, resp_ok)
        wait_resp(1'b0);
        `CHK("osc", cont, osc_continuous)
    endtask : run
    initial begin
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        `CHK("alive init", 1'b0, status.module_alive)
        `CHK("osc start", 1'b0, osc_continuous)
        repeat (17) @(negedge mclk);
        `CHK("alive", 1'b1, status.module_alive)
        for (int i = 0; i < 7; i++) begin
            wait_cyc = 4'(i + 1);
            run(tbl[i], i != 1);
            $display("test %0d done", i);
        end
        wait_cyc = 4'h9;
        issue(12'h410);
        @(negedge mclk);
        abort_n = 1'b0;
        #1;
        `CHK("abort antenna", 1'b0, antenna_on)
        `CHK("abort tag_go", 1'b0, tag_go)
        `CHK("abort alive", 1'b0, status.module_alive)
        repeat (4) @(negedge mclk);
        abort_n = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK("alive back", 1'b1, status.module_alive)
        cont = 1'b1;
        run(12'h808, 1'b1);
        $display("test abort done");
        give_verdict();
    end
endmodule : rfseq_top_tb
bind rfseq_top rfseq_sva rfseq_sva_i (.mclk, .rst_n, .abort_n, .tag_go,
    .tag_done, .tag_ok, .resp_go, .resp_done, .antenna_on, .osc_continuous,
    .status);
`default_nettype wire
